// *** temp_limit_pkg.sv ***
// Constants, register map and timing figures of the temperature monitor
// Functional notes
// - Lines low past timeout reset serial logic
// - Readings are signed; remote is ten bits plus sign
// - Critical trip low from above limit until remote at or below limit minus hysteresis
// - Compare local reading with local high limit
// - Compare remote with high, low, critical limits
// - Alarm on above high/critical or below low
// - Alarm mask bit suppresses alarm output
// - Hysteresis decides when a condition clears
// - Standby bit stops continuous conversions
// - Standby PWM continues or stops per bit
// - Local reading and limits are eight bits
// - Remote reading left justified, two bytes
// - Remote reading corrected by signed offset pair
// - Fan speed counted from tachometer pulses
// - Fixed conversion time, idle delay sets rate
// - Status set per reading; drives alarm low
// - Status cleared by read except in comparator mode; host clears mask
package temp_limit_pkg;
	// Timing, in ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int TIMEOUT_MIN_NS = 25_000_000;
	localparam int TIMEOUT_MAX_NS = 35_000_000;
	localparam int CONV_TIME_NS = 31_250_000;
	localparam int FAN_PULSE_INPUT_WINDOW_NS = 1_000_000_000;
	// Register offsets
	localparam logic [7:0] CONFIG = 8'h00;
	localparam logic [7:0] CONV_RATE = 8'h01;
	localparam logic [7:0] LOCAL_TEMP = 8'h02;
	localparam logic [7:0] LOCAL_HIGH = 8'h03;
	localparam logic [7:0] REMOTE_TEMP_HI = 8'h04;
	localparam logic [7:0] REMOTE_TEMP_LO = 8'h05;
	localparam logic [7:0] REMOTE_HIGH_HI = 8'h06;
	localparam logic [7:0] REMOTE_HIGH_LO = 8'h07;
	localparam logic [7:0] REMOTE_LOW_HI = 8'h08;
	localparam logic [7:0] REMOTE_LOW_LO = 8'h09;
	localparam logic [7:0] REMOTE_CRIT_HI = 8'h0A;
	localparam logic [7:0] REMOTE_CRIT_LO = 8'h0B;
	localparam logic [7:0] HYSTERESIS = 8'h0C;
	localparam logic [7:0] OFFSET_HI = 8'h0D;
	localparam logic [7:0] OFFSET_LO = 8'h0E;
	localparam logic [7:0] STATUS = 8'h0F;
	localparam logic [7:0] IRQ_MASK = 8'h10;
	localparam logic [7:0] FAN_PULSE_INPUT_LO = 8'h11;
	localparam logic [7:0] FAN_PULSE_INPUT_HI = 8'h12;
	localparam logic [7:0] PWM_DUTY = 8'h13;
	// Configuration bits
	localparam int CFG_ALARM_MASK = 0;
	localparam int CFG_STANDBY = 1;
	localparam int CFG_PWM_OFF_STBY = 2;
	localparam int CFG_COMPARATOR = 3;
	// Status bits
	localparam int ST_LOCAL_HIGH = 0;
	localparam int ST_REMOTE_HIGH = 1;
	localparam int ST_REMOTE_LOW = 2;
	localparam int ST_REMOTE_CRIT = 3;
	localparam int ST_BUSY = 7;
	localparam logic [7:0] ALARM_BITS = 8'h0F;
	// Reset values
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] RATE_RST = 8'h00;
	localparam logic [7:0] LOCAL_HIGH_RST = 8'h46;
	localparam logic [15:0] REMOTE_HIGH_RST = 16'h4600;
	localparam logic [15:0] REMOTE_LOW_RST = 16'h0000;
	localparam logic [15:0] REMOTE_CRIT_RST = 16'h5500;
	localparam logic [7:0] HYST_RST = 8'h0A;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] FAN_PULSE_INPUT_FULL = 16'hFFFF;
endpackage

// *** temp_limit_alert_monitor.sv ***
// Digital back end: readings, limits, alarm, standby, PWM, fan_pulse_input, timeout
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module temp_limit_alert_monitor #(
	parameter int TIMEOUT_CYC = (temp_limit_pkg::TIMEOUT_MIN_NS
		+ temp_limit_pkg::CLK_PERIOD_NS - 1) / temp_limit_pkg::CLK_PERIOD_NS,
	parameter int CONV_CYC = temp_limit_pkg::CONV_TIME_NS
		/ temp_limit_pkg::CLK_PERIOD_NS,
	parameter int FAN_PULSE_INPUT_CYC = temp_limit_pkg::FAN_PULSE_INPUT_WINDOW_NS
		/ temp_limit_pkg::CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Converter results, same clock
	input wire logic [7:0] local_adc_i,
	input wire logic [10:0] remote_adc_i,
	output logic conv_busy_o,
	// Serial lines and serial engine pull requests
	input wire logic smb_clk_i,
	input wire logic smb_dat_i,
	input wire logic clk_pull_i,
	input wire logic dat_pull_i,
	output logic smb_clk_oe_o,
	output logic smb_dat_oe_o,
	output logic serial_reset_o,
	// Fan
	input wire logic fan_pulse_input_i,
	output logic pwm_o,
	// Alarms
	output logic alert_n_o,
	output logic tcrit_n_o,
	output logic irq_o
);
	typedef enum logic [1:0] {S_STANDBY, S_CONV, S_WAIT} conv_e;

	conv_e state;
	logic [7:0] config_reg, conv_rate, local_high, hyst, irq_mask, pwm_duty;
	logic [15:0] remote_high, remote_low, remote_crit, remote_offset;
	logic [7:0] local_temp_reading;
	logic [10:0] remote_temp_reading;
	logic [7:0] status;
	logic [3:0] active;
	logic [31:0] cyc_cnt, fan_pulse_input_win, line_low_cnt;
	logic [7:0] slot_cnt, pwm_cnt;
	logic [15:0] fan_pulse_input_cnt, fan_pulse_input_value;
	logic [1:0] clk_sync, dat_sync;
	logic [2:0] fan_sync;
	logic timed_out;

	// Register decode
	wire wr_cfg = wr_i && addr_i == temp_limit_pkg::CONFIG;
	wire wr_status = wr_i && addr_i == temp_limit_pkg::STATUS;
	wire rd_status = rd_i && addr_i == temp_limit_pkg::STATUS;
	wire standby = config_reg[temp_limit_pkg::CFG_STANDBY];
	wire comparator = config_reg[temp_limit_pkg::CFG_COMPARATOR];

	// Conversion timing
	wire conv_last = cyc_cnt == 32'(CONV_CYC - 1);
	wire eoc = state == S_CONV && conv_last;
	wire [7:0] idle_slots = 8'((9'h001 << conv_rate[2:0]) - 9'h001);

	// signed offset, remote units of 1/8 degree
	wire signed [11:0] offset_sum = 12'(signed'(remote_adc_i))
		+ 12'(signed'(remote_offset[15:5]));
	// saturate to ten bits plus sign
	wire [10:0] remote_corr = (offset_sum > 12'sd1023) ? 11'h3FF :
		(offset_sum < -12'sd1024) ? 11'h400 : offset_sum[10:0];

	// Comparison operands widened, 1/8 degree units for remote
	wire signed [12:0] r_val = 13'(signed'(remote_corr));
	wire signed [12:0] r_hi = 13'(signed'(remote_high[15:5]));
	wire signed [12:0] r_lo = 13'(signed'(remote_low[15:5]));
	wire signed [12:0] r_cr = 13'(signed'(remote_crit[15:5]));
	wire signed [12:0] r_hy = signed'({2'b00, hyst, 3'b000});
	wire signed [9:0] l_val = 10'(signed'(local_adc_i));
	wire signed [9:0] l_hi = 10'(signed'(local_high));
	wire signed [9:0] l_hy = signed'({2'b00, hyst});

	wire l_hi_set = l_val > l_hi;
	// clears only at or below limit minus hysteresis
	wire l_hi_clr = l_val <= l_hi - l_hy;
	// remote against high, low and critical
	wire r_hi_set = r_val > r_hi;
	wire r_hi_clr = r_val <= r_hi - r_hy;
	wire r_lo_set = r_val < r_lo;
	wire r_lo_clr = r_val >= r_lo + r_hy;
	wire r_cr_set = r_val > r_cr;
	wire r_cr_clr = r_val <= r_cr - r_hy;
	wire [3:0] cond_set = {r_cr_set, r_lo_set, r_hi_set, l_hi_set};
	wire [3:0] cond_clr = {r_cr_clr, r_lo_clr, r_hi_clr, l_hi_clr};
	wire [3:0] next_active = (active | cond_set) & ~(cond_clr & ~cond_set);

	// status from each reading; read clears except in comparator mode, set wins
	wire [3:0] st_clear = (rd_status ? 4'hF : 4'h0)
		| (wr_status ? wdata_i[3:0] : 4'h0);
	wire [3:0] st_set = eoc ? next_active : 4'h0;
	wire [3:0] next_status = comparator ? (eoc ? next_active : active)
		: ((status[3:0] & ~st_clear) | st_set);
	// read of pending status outside comparator mode sets the alarm mask
	wire mask_on_read = rd_status && !comparator && (|status[3:0]);
	wire [3:0] pending = status[3:0] & ~irq_mask[3:0];

	// either line low counts toward the timeout
	wire line_low = !clk_sync[1] || !dat_sync[1];
	wire fan_rise = fan_sync[1] && !fan_sync[2];
	wire fan_pulse_input_end = fan_pulse_input_win == 32'(FAN_PULSE_INPUT_CYC - 1);

	// Read mux
	logic [7:0] read_word;
	always_comb begin
		unique case (addr_i)
			temp_limit_pkg::CONFIG: read_word = config_reg;
			temp_limit_pkg::CONV_RATE: read_word = conv_rate;
			temp_limit_pkg::LOCAL_TEMP: read_word = local_temp_reading;
			temp_limit_pkg::LOCAL_HIGH: read_word = local_high;
			temp_limit_pkg::REMOTE_TEMP_HI: read_word = remote_temp_reading[10:3];
			temp_limit_pkg::REMOTE_TEMP_LO:
				read_word = {remote_temp_reading[2:0], 5'b00000};
			temp_limit_pkg::REMOTE_HIGH_HI: read_word = remote_high[15:8];
			temp_limit_pkg::REMOTE_HIGH_LO: read_word = remote_high[7:0];
			temp_limit_pkg::REMOTE_LOW_HI: read_word = remote_low[15:8];
			temp_limit_pkg::REMOTE_LOW_LO: read_word = remote_low[7:0];
			temp_limit_pkg::REMOTE_CRIT_HI: read_word = remote_crit[15:8];
			temp_limit_pkg::REMOTE_CRIT_LO: read_word = remote_crit[7:0];
			temp_limit_pkg::HYSTERESIS: read_word = hyst;
			temp_limit_pkg::OFFSET_HI: read_word = remote_offset[15:8];
			temp_limit_pkg::OFFSET_LO: read_word = remote_offset[7:0];
			temp_limit_pkg::STATUS: read_word = status;
			temp_limit_pkg::IRQ_MASK: read_word = irq_mask;
			temp_limit_pkg::FAN_PULSE_INPUT_LO: read_word = fan_pulse_input_value[7:0];
			temp_limit_pkg::FAN_PULSE_INPUT_HI: read_word = fan_pulse_input_value[15:8];
			temp_limit_pkg::PWM_DUTY: read_word = pwm_duty;
			default: read_word = temp_limit_pkg::ZERO8;
		endcase
	end

	// register port has no standby gating
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			rdata_o <= temp_limit_pkg::ZERO8;
		end else begin
			rdata_o <= rd_i ? read_word : temp_limit_pkg::ZERO8;
		end
	end

	// Writable registers
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			config_reg <= temp_limit_pkg::CONFIG_RST;
			conv_rate <= temp_limit_pkg::RATE_RST;
			local_high <= temp_limit_pkg::LOCAL_HIGH_RST;
			remote_high <= temp_limit_pkg::REMOTE_HIGH_RST;
			remote_low <= temp_limit_pkg::REMOTE_LOW_RST;
			remote_crit <= temp_limit_pkg::REMOTE_CRIT_RST;
			hyst <= temp_limit_pkg::HYST_RST;
			remote_offset <= temp_limit_pkg::ZERO16;
			irq_mask <= temp_limit_pkg::ZERO8;
			pwm_duty <= temp_limit_pkg::ZERO8;
		end else begin
			if (wr_cfg) begin
				config_reg <= wdata_i;
			end else if (mask_on_read) begin
				config_reg[temp_limit_pkg::CFG_ALARM_MASK] <= 1'b1;
			end
			if (wr_i) begin
				unique case (addr_i)
					temp_limit_pkg::CONV_RATE: conv_rate <= wdata_i;
					temp_limit_pkg::LOCAL_HIGH: local_high <= wdata_i;
					temp_limit_pkg::REMOTE_HIGH_HI: remote_high[15:8] <= wdata_i;
					temp_limit_pkg::REMOTE_HIGH_LO: remote_high[7:0] <= wdata_i;
					temp_limit_pkg::REMOTE_LOW_HI: remote_low[15:8] <= wdata_i;
					temp_limit_pkg::REMOTE_LOW_LO: remote_low[7:0] <= wdata_i;
					temp_limit_pkg::REMOTE_CRIT_HI: remote_crit[15:8] <= wdata_i;
					temp_limit_pkg::REMOTE_CRIT_LO: remote_crit[7:0] <= wdata_i;
					temp_limit_pkg::HYSTERESIS: hyst <= wdata_i;
					temp_limit_pkg::OFFSET_HI: remote_offset[15:8] <= wdata_i;
					temp_limit_pkg::OFFSET_LO: remote_offset[7:0] <= wdata_i;
					temp_limit_pkg::IRQ_MASK: irq_mask <= wdata_i;
					temp_limit_pkg::PWM_DUTY: pwm_duty <= wdata_i;
					default: ;
				endcase
			end
		end
	end

	// fixed conversion, then whole idle conversion slots
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state <= S_CONV;
			cyc_cnt <= '0;
			slot_cnt <= temp_limit_pkg::ZERO8;
		end else if (standby) begin
			state <= S_STANDBY;
			cyc_cnt <= '0;
			slot_cnt <= temp_limit_pkg::ZERO8;
		end else begin
			cyc_cnt <= conv_last ? '0 : cyc_cnt + 32'd1;
			unique case (state)
				S_STANDBY: begin
					state <= S_CONV;
					cyc_cnt <= '0;
				end
				S_CONV: begin
					if (conv_last && idle_slots != 8'h00) begin
						state <= S_WAIT;
						slot_cnt <= idle_slots;
					end
				end
				S_WAIT: begin
					if (conv_last) begin
						slot_cnt <= slot_cnt - 8'h01;
						if (slot_cnt == 8'h01) begin
							state <= S_CONV;
						end
					end
				end
			endcase
		end
	end

	// Readings, conditions, status and alarm outputs
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			local_temp_reading <= temp_limit_pkg::ZERO8;
			remote_temp_reading <= '0;
			active <= 4'h0;
			status <= temp_limit_pkg::ZERO8;
			conv_busy_o <= 1'b0;
			alert_n_o <= 1'b1;
			tcrit_n_o <= 1'b1;
			irq_o <= 1'b0;
		end else begin
			if (eoc) begin
				local_temp_reading <= local_adc_i;
				remote_temp_reading <= remote_corr;
				active <= next_active;
			end
			status[3:0] <= next_status;
			status[temp_limit_pkg::ST_BUSY] <= state == S_CONV;
			conv_busy_o <= state == S_CONV;
			irq_o <= |pending;
			// any set limit status bit; mask suppresses
			// IRQ mask gates only irq_o, never the alarm pin
			alert_n_o <= !((|status[3:0])
				&& !config_reg[temp_limit_pkg::CFG_ALARM_MASK]);
			tcrit_n_o <= !(eoc ? next_active[3] : active[3]);
		end
	end

	// Line synchronisers and timeout
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			clk_sync <= 2'b11;
			dat_sync <= 2'b11;
			line_low_cnt <= '0;
			timed_out <= 1'b0;
			serial_reset_o <= 1'b0;
			smb_clk_oe_o <= 1'b0;
			smb_dat_oe_o <= 1'b0;
		end else begin
			clk_sync <= {clk_sync[0], smb_clk_i};
			dat_sync <= {dat_sync[0], smb_dat_i};
			line_low_cnt <= line_low ? line_low_cnt + 32'd1 : '0;
			serial_reset_o <= 1'b0;
			// reset serial logic, release both lines
			if (line_low && line_low_cnt == 32'(TIMEOUT_CYC - 1)) begin
				timed_out <= 1'b1;
				serial_reset_o <= 1'b1;
			end else if (!line_low) begin
				timed_out <= 1'b0;
			end
			smb_clk_oe_o <= clk_pull_i && !timed_out
				&& !(line_low && line_low_cnt == 32'(TIMEOUT_CYC - 1));
			smb_dat_oe_o <= dat_pull_i && !timed_out
				&& !(line_low && line_low_cnt == 32'(TIMEOUT_CYC - 1));
		end
	end

	// rising fan_pulse_input edges counted per window, saturating
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			// Pulled-up pin idles high; no false edge after reset
			fan_sync <= 3'b111;
			fan_pulse_input_win <= '0;
			fan_pulse_input_cnt <= temp_limit_pkg::ZERO16;
			fan_pulse_input_value <= temp_limit_pkg::ZERO16;
		end else begin
			fan_sync <= {fan_sync[1:0], fan_pulse_input_i};
			fan_pulse_input_win <= fan_pulse_input_end ? '0 : fan_pulse_input_win + 32'd1;
			if (fan_pulse_input_end) begin
				fan_pulse_input_value <= fan_pulse_input_cnt;
				fan_pulse_input_cnt <= temp_limit_pkg::ZERO16;
			end else if (fan_rise && fan_pulse_input_cnt != temp_limit_pkg::FAN_PULSE_INPUT_FULL) begin
				fan_pulse_input_cnt <= fan_pulse_input_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			pwm_cnt <= temp_limit_pkg::ZERO8;
			pwm_o <= 1'b0;
		end else begin
			pwm_cnt <= pwm_cnt + 8'h01;
			pwm_o <= pwm_cnt < pwm_duty && !(standby
				&& config_reg[temp_limit_pkg::CFG_PWM_OFF_STBY]);
		end
	end
endmodule // temp_limit_alert_monitor

// *** temp_limit_sva.sv ***
// Port assertions for the temperature monitor
`timescale 1ns/1ps
module temp_limit_sva #(
	parameter int TIMEOUT_CYC = 50
) (
	// Clock, reset and register port
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic conv_busy_o,
	// Serial lines
	input wire logic smb_clk_i,
	input wire logic smb_dat_i,
	input wire logic clk_pull_i,
	input wire logic dat_pull_i,
	input wire logic smb_clk_oe_o,
	input wire logic smb_dat_oe_o,
	input wire logic serial_reset_o,
	// Outputs
	input wire logic pwm_o,
	input wire logic alert_n_o,
	input wire logic tcrit_n_o,
	input wire logic irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	int low_cnt;
	// Raw low time; leads the synced view by two cycles
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i || (smb_clk_i && smb_dat_i)) begin
			low_cnt <= 0;
		end else if (low_cnt < TIMEOUT_CYC + 9) begin
			low_cnt <= low_cnt + 1;
		end
	end
	property p_tmo_fire;
		low_cnt == TIMEOUT_CYC |-> ##[0:5] serial_reset_o;
	endproperty
	a_tmo_fire: assert property (p_tmo_fire)
		else $error("stuck line gave no serial reset");
	property p_tmo_early;
		serial_reset_o |-> low_cnt >= TIMEOUT_CYC;
	endproperty
	a_tmo_early: assert property (p_tmo_early)
		else $error("serial reset before timeout");
	property p_tmo_pulse;
		serial_reset_o |=> !serial_reset_o;
	endproperty
	a_tmo_pulse: assert property (p_tmo_pulse)
		else $error("serial reset longer than one cycle");
	property p_tmo_release;
		serial_reset_o |=> !smb_clk_oe_o && !smb_dat_oe_o;
	endproperty
	a_tmo_release: assert property (p_tmo_release)
		else $error("lines not released after timeout");
	property p_oe_cause;
		!$past(clk_pull_i) && !$past(dat_pull_i) |->
			!smb_clk_oe_o && !smb_dat_oe_o;
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("line pulled without request");
	property p_rdata_idle;
		!$past(rd_i) |-> rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");
	property p_rst_out;
		!$past(nrst_i) |-> alert_n_o && tcrit_n_o && !irq_o && !pwm_o
			&& !conv_busy_o && !smb_clk_oe_o;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs wrong after reset");
	property p_status_read;
		rd_i && addr_i == temp_limit_pkg::STATUS && !conv_busy_o |->
			##2 (!irq_o && alert_n_o) ##1 alert_n_o;
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read did not clear alarm");
	property p_busy_quiet;
		!conv_busy_o && !$past(conv_busy_o) |-> $stable(tcrit_n_o);
	endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("critical output moved between conversions");
endmodule // temp_limit_sva
bind temp_limit_alert_monitor temp_limit_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .conv_busy_o(conv_busy_o), .smb_clk_i(smb_clk_i),
	.smb_dat_i(smb_dat_i), .clk_pull_i(clk_pull_i), .dat_pull_i(dat_pull_i),
	.smb_clk_oe_o(smb_clk_oe_o), .smb_dat_oe_o(smb_dat_oe_o),
	.serial_reset_o(serial_reset_o), .pwm_o(pwm_o), .alert_n_o(alert_n_o),
	.tcrit_n_o(tcrit_n_o), .irq_o(irq_o)
);

// *** smb_host_model.sv ***
// Bus host model: open-drain lines with pull-ups
`timescale 1ns/1ps
module smb_host_model (
	// Bench control
	input wire logic frame_i,
	input wire logic stuck_i,
	// Device pull-downs
	input wire logic clk_oe_i,
	input wire logic dat_oe_i,
	// Resolved line levels
	output logic smb_clk_o,
	output logic smb_dat_o
);
	logic host_clk = 1'b1;
	logic host_dat = 1'b1;
	// Clock runs only within frames
	initial begin
		#5;
		forever begin
			#32;
			host_clk = frame_i ? ~host_clk : 1'b1;
			if (!host_clk) host_dat = ~host_dat;
		end
	end
	// Released lines float to the pull-up level
	assign smb_clk_o = ~(clk_oe_i | stuck_i) & host_clk;
	assign smb_dat_o = ~dat_oe_i & (host_dat | ~frame_i);
endmodule // smb_host_model

// *** tb.sv ***
// Self-checking bench for the temperature monitor
`timescale 1ns/1ps
module tb;
	localparam int TMO = 50;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic [7:0] local_adc_i = 8'h20;
	logic [10:0] remote_adc_i = 11'h100;
	logic conv_busy_o, smb_clk_i, smb_dat_i, smb_clk_oe_o, smb_dat_oe_o;
	logic clk_pull_i = 1'b0;
	logic dat_pull_i = 1'b0;
	logic fan_pulse_input_i = 1'b1;
	logic serial_reset_o, pwm_o, alert_n_o, tcrit_n_o, irq_o;
	logic frame = 1'b0;
	logic stuck = 1'b0;
	logic [31:0] seed = 32'hE760AD3A;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int sr_cnt = 0;
	int hi, bz;
	temp_limit_alert_monitor #(.TIMEOUT_CYC(TMO), .CONV_CYC(40),
		.FAN_PULSE_INPUT_CYC(200)) dut (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.local_adc_i(local_adc_i), .remote_adc_i(remote_adc_i),
		.conv_busy_o(conv_busy_o), .smb_clk_i(smb_clk_i),
		.smb_dat_i(smb_dat_i), .clk_pull_i(clk_pull_i),
		.dat_pull_i(dat_pull_i), .smb_clk_oe_o(smb_clk_oe_o),
		.smb_dat_oe_o(smb_dat_oe_o), .serial_reset_o(serial_reset_o),
		.fan_pulse_input_i(fan_pulse_input_i), .pwm_o(pwm_o),
		.alert_n_o(alert_n_o), .tcrit_n_o(tcrit_n_o), .irq_o(irq_o));
	smb_host_model host (.frame_i(frame), .stuck_i(stuck),
		.clk_oe_i(smb_clk_oe_o), .dat_oe_i(smb_dat_oe_o),
		.smb_clk_o(smb_clk_i), .smb_dat_o(smb_dat_i));
	initial begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// Watchdog, serial reset count, fan_pulse_input at ten cycles a pulse
	always @(posedge sys_clk_i) begin
		cyc++;
		if (serial_reset_o === 1'b1) sr_cnt++;
		if (cyc % 5 == 0) fan_pulse_input_i <= ~fan_pulse_input_i;
		if (cyc == 40000) begin
			num_errors++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Offset sum saturates to eleven signed bits
	function automatic logic [10:0] corr(input logic [10:0] r,
		input logic [10:0] o);
		logic signed [11:0] s;
		s = $signed({r[10], r}) + $signed({o[10], o});
		if (s > 12'sd1023) return 11'h3FF;
		if (s < -12'sd1024) return 11'h400;
		return s[10:0];
	endfunction
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] v);
		checks_done++;
		if (v !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk("register", {a, e}, {a, v});
	endtask
	// Two busy falls, so the second reading saw current inputs
	task automatic conv();
		int n;
		n = 0;
		repeat (2) begin
			while (conv_busy_o !== 1'b1 && n < 400) @(posedge sys_clk_i) n++;
			while (conv_busy_o !== 1'b0 && n < 400) @(posedge sys_clk_i) n++;
		end
		chk("conv_done", 16'h0000, 16'(n >= 400));
		repeat (3) @(posedge sys_clk_i);
	endtask
	task automatic count(input int n);
		hi = 0;
		bz = 0;
		repeat (n) begin
			@(posedge sys_clk_i);
			#1;
			if (pwm_o === 1'b1) hi++;
			if (conv_busy_o !== 1'b0) bz++;
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] v;
		logic [10:0] r, o;
		repeat (10) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rc(temp_limit_pkg::CONFIG, temp_limit_pkg::CONFIG_RST);
		rc(temp_limit_pkg::LOCAL_HIGH, temp_limit_pkg::LOCAL_HIGH_RST);
		rc(temp_limit_pkg::REMOTE_HIGH_HI, 8'h46);
		rc(temp_limit_pkg::REMOTE_CRIT_LO, 8'h00);
		rc(temp_limit_pkg::HYSTERESIS, temp_limit_pkg::HYST_RST);
		rc(8'hFF, 8'h00);
		wr(temp_limit_pkg::CONV_RATE, 8'h01);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			r = (i == 2) ? 11'h3FF : {3'b000, seed[7:0]} + 11'h040;
			o = (i == 2) ? 11'h01F : {{5{seed[13]}}, seed[13:8]};
			wr(temp_limit_pkg::OFFSET_HI, o[10:3]);
			wr(temp_limit_pkg::OFFSET_LO, {o[2:0], 5'h00});
			remote_adc_i <= r;
			conv();
			r = corr(r, o);
			rc(temp_limit_pkg::REMOTE_TEMP_HI, r[10:3]);
			rc(temp_limit_pkg::REMOTE_TEMP_LO, {r[2:0], 5'h00});
		end
		chk("tcrit", 1'b0, tcrit_n_o);
		wr(temp_limit_pkg::OFFSET_HI, 8'h00);
		wr(temp_limit_pkg::OFFSET_LO, 8'h00);
		remote_adc_i <= 11'h2A0;
		conv();
		chk("tcrit", 1'b0, tcrit_n_o);
		remote_adc_i <= 11'h250;
		conv();
		chk("tcrit", 1'b1, tcrit_n_o);
		chk("alert", 1'b0, alert_n_o);
		chk("irq", 1'b1, irq_o);
		rd(temp_limit_pkg::STATUS, v);
		chk("status", 8'h0A, v & temp_limit_pkg::ALARM_BITS);
		rc(temp_limit_pkg::CONFIG, 8'h01);
		conv();
		chk("alert", 1'b1, alert_n_o);
		chk("irq", 1'b1, irq_o);
		wr(temp_limit_pkg::IRQ_MASK, 8'h0F);
		wr(temp_limit_pkg::STATUS, 8'h0F);
		conv();
		chk("irq", 1'b0, irq_o);
		local_adc_i <= 8'h47;
		wr(temp_limit_pkg::CONFIG, 8'h00);
		conv();
		chk("alert", 1'b0, alert_n_o);
		rd(temp_limit_pkg::STATUS, v);
		chk("status", 8'h03, v & temp_limit_pkg::ALARM_BITS);
		// Comparator mode: low limit, release without a read
		wr(temp_limit_pkg::CONFIG, 8'h08);
		local_adc_i <= 8'h20;
		remote_adc_i <= 11'h100;
		wr(temp_limit_pkg::REMOTE_LOW_HI, 8'h50);
		conv();
		chk("alert_low", 1'b0, alert_n_o);
		wr(temp_limit_pkg::REMOTE_LOW_HI, 8'h00);
		conv();
		chk("alert_cmp", 1'b1, alert_n_o);
		seed = xs(seed);
		wr(temp_limit_pkg::PWM_DUTY, seed[7:0]);
		wr(temp_limit_pkg::CONFIG, 8'h06);
		repeat (3) @(posedge sys_clk_i);
		count(300);
		chk("pwm_standby", 16'h0000, hi);
		chk("busy_standby", 16'h0000, bz);
		rc(temp_limit_pkg::LOCAL_HIGH, 8'h46);
		wr(temp_limit_pkg::CONFIG, 8'h02);
		repeat (3) @(posedge sys_clk_i);
		count(256);
		chk("pwm_high", {8'h00, seed[7:0]}, hi);
		rd(temp_limit_pkg::FAN_PULSE_INPUT_LO, v);
		chk("fan_pulse_input", 1'b1, v >= 8'h13 && v <= 8'h15);
		wr(temp_limit_pkg::CONFIG, 8'h00);
		repeat (5) @(posedge sys_clk_i);
		chk("busy_resume", 1'b1, conv_busy_o);
		frame <= 1'b1;
		repeat (100) begin
			@(posedge sys_clk_i);
			seed = xs(seed);
			dat_pull_i <= seed[0] & seed[3];
			clk_pull_i <= seed[1] & seed[2];
		end
		frame <= 1'b0;
		dat_pull_i <= 1'b0;
		clk_pull_i <= 1'b1;
		stuck <= 1'b1;
		repeat (TMO + 30) @(posedge sys_clk_i);
		chk("serial_reset", 16'h0001, sr_cnt);
		chk("clk_oe", 1'b0, smb_clk_oe_o);
		stuck <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		#1;
		chk("clk_oe", 1'b1, smb_clk_oe_o);
		report_and_stop();
	end
endmodule // tb
